// ### rtl/fsps_seq.sv
// Flash self-program sequencer with APB registers and CPU store-program port
// Rules from the document
// R1: Reset vector is zero when boot reset fuse is 0, boot start when 1.
// R2: Boot code may read and program every flash location, boot section included.
// R3: General lock bits never block store-program or load-program accesses.
// R4: Flash changes only by whole 64-word pages, never a single word.
// R5: Software erases, loads buffer words, then writes; it saves unchanged words.
// R6: Buffer words may be loaded in any index order.
// R7: Code 00011 then store-program erases page at pointer bits 14..7.
// R8: Code 00001 then store-program loads R1:R0 into slot pointer bits 6..1.
// R9: Code 00101 writes buffer into page 14..7; software keeps bits 6..0 zero.
// R10: Software uses the same page address for erase and following write.
// R11: Store-program acts only within four cycles after the command write.
// R12: CPU halts during erase or write; enable flag clears on completion.
// R13: Software polls the command register until the enable flag clears.
// R14: Software follows erase or write with an all-ones word and a no-op.
// R15: Software should keep interrupts disabled during erase or write.
// R16: Software should lock the boot section when it need not change.
// R17: Store-program executes only when fetched from the boot section.
// R18: Flash is 256 pages of 64 words; boot size set by two fuses.
// R19: A late or missing store-program clears the command, no flash action.
`timescale 1ns/1ps
module fsps_seq #(
    parameter int PROG_CYCLES = fsps_pkg::PROG_TIME_US * fsps_pkg::NS_PER_US
                                / fsps_pkg::CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic spm_strobe,
    input wire logic [13:0] spm_pc,
    input wire logic [15:0] z_ptr,
    input wire logic [15:0] r1r0,
    input wire logic boot_reset_select_fuse,
    input wire logic [1:0] boot_size_fuses,
    output logic [13:0] reset_vec,
    output logic cpu_halt,
    output logic flash_erase,
    output logic [7:0] flash_page,
    output logic flash_wr_en,
    output logic [5:0] flash_wr_idx,
    output logic [15:0] flash_wr_data,
    output logic irq
);
    localparam int CNT_W = $clog2(PROG_CYCLES + 1);
    localparam int IW = fsps_pkg::IDX_W;

    fsps_pkg::fsps_state_t state_r;
    logic [fsps_pkg::CMD_W-1:0] cmd_r;
    logic [2:0] win_cnt_r;
    logic [CNT_W-1:0] prog_cnt_r;
    logic [IW-1:0] wr_idx_r;
    logic op_write_r;
    logic [fsps_pkg::ST_W-1:0] status_r;
    logic [fsps_pkg::ST_W-1:0] mask_r;
    logic [fsps_pkg::ST_W-1:0] status_nxt;
    logic [15:0] buf_rd;

    // Bus decode
    wire idle = (state_r == fsps_pkg::FSPS_IDLE);
    wire access = psel && penable && !pready;
    wire fire = psel && penable && pready;
    wire wr_fire = fire && pwrite;
    wire rd_fire = fire && !pwrite;
    wire hit_cmd = (paddr == fsps_pkg::ADDR_CMD);
    wire hit_status = (paddr == fsps_pkg::ADDR_STATUS);
    wire hit_mask = (paddr == fsps_pkg::ADDR_MASK);
    wire hit_info = (paddr == fsps_pkg::ADDR_INFO);
    wire hit_any = hit_cmd || hit_status || hit_mask || hit_info;
    // Command writes while busy are dropped so a running page is never re-aimed
    wire cmd_wr = wr_fire && hit_cmd && idle;
    wire cmd_wr_en = cmd_wr && pwdata[fsps_pkg::CMD_ENABLE_BIT];

    // R18: boot start from the two size fuses
    wire [13:0] boot_start =
        (boot_size_fuses == fsps_pkg::BOOT_SIZE_FUSES_256) ? fsps_pkg::BOOT_START_256 :
        (boot_size_fuses == fsps_pkg::BOOT_SIZE_FUSES_512) ? fsps_pkg::BOOT_START_512 :
        (boot_size_fuses == fsps_pkg::BOOT_SIZE_FUSES_1K) ? fsps_pkg::BOOT_START_1K :
        fsps_pkg::BOOT_START_2K;
    // R17: only fetches from the boot section count
    wire in_boot = (spm_pc >= boot_start);

    // R11: store-program honoured only inside the armed window
    wire win_active = (win_cnt_r != 3'h0) && cmd_r[fsps_pkg::CMD_ENABLE_BIT];
    wire spm_take = spm_strobe && win_active;
    wire spm_ok = spm_take && in_boot;
    wire spm_refused = spm_take && !in_boot;
    // R19: window ran out without a store-program
    wire win_expire = (win_cnt_r == 3'h1) && !spm_strobe && cmd_r[fsps_pkg::CMD_ENABLE_BIT];

    // R7: page erase code
    wire start_erase = spm_ok && (cmd_r == fsps_pkg::CMD_PAGE_ERASE);
    // R9: page write code
    wire start_write = spm_ok && (cmd_r == fsps_pkg::CMD_PAGE_WRITE);
    // R8: buffer load code
    wire start_load = spm_ok && (cmd_r == fsps_pkg::CMD_PAGE_LOAD);
    wire other_cmd = spm_ok && !start_erase && !start_write && !start_load;
    wire prog_end = (state_r == fsps_pkg::FSPS_WAIT) && (prog_cnt_r == '0);
    wire stream_end = (state_r == fsps_pkg::FSPS_WRITE)
                      && (wr_idx_r == IW'(fsps_pkg::PAGE_WORDS - 1));

    // R2 R3: target page from the pointer alone, no section or lock gating
    wire [7:0] z_page = z_ptr[fsps_pkg::Z_PAGE_HI:fsps_pkg::Z_PAGE_LO];
    wire [IW-1:0] z_idx = z_ptr[fsps_pkg::Z_IDX_HI:fsps_pkg::Z_IDX_LO];

    // Events for the sticky status register
    wire ev_done = prog_end || start_load || other_cmd;
    wire ev_timeout = win_expire;
    wire ev_refused = spm_refused;
    wire [fsps_pkg::ST_W-1:0] events = {ev_refused, ev_timeout, ev_done};
    // Clear only bits already returned, and a new event wins over the clear
    wire [fsps_pkg::ST_W-1:0] rd_clear =
        (rd_fire && hit_status) ? prdata[fsps_pkg::ST_W-1:0] : '0;
    assign status_nxt = (status_r & ~rd_clear) | events;

    wire [31:0] rd_value =
        hit_cmd ? {27'h0, cmd_r} :
        hit_status ? {29'h0, status_r} :
        hit_mask ? {29'h0, mask_r} :
        hit_info ? {15'h0, !idle, 2'h0, reset_vec} :
        32'h0;

    // R6: buffer loaded at the pointer index, any order
    fsps_page_buf #(
        .WORDS(fsps_pkg::PAGE_WORDS),
        .WIDTH(fsps_pkg::WORD_W),
        .IDX_W(IW)
    ) u_buf (
        .clk(clk),
        .rst_b(rst_b),
        .load_en(start_load),
        .load_idx(z_idx),
        .load_data(r1r0),
        .clear(prog_end && op_write_r),
        .rd_idx(wr_idx_r),
        .rd_data(buf_rd)
    );

    // APB slave with one wait state
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else
        begin
            pready <= access;
            pslverr <= access && !hit_any;
            prdata <= (access && !pwrite) ? rd_value : 32'h0;
        end
    end

    // R1: reset vector chosen by the boot reset fuse
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            reset_vec <= fsps_pkg::APP_RESET_VEC;
        else
            reset_vec <= boot_reset_select_fuse ? boot_start : fsps_pkg::APP_RESET_VEC;
    end

    // Command register and its window
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            cmd_r <= '0;
            win_cnt_r <= 3'h0;
        end
        else if (cmd_wr)
        begin
            cmd_r <= pwdata[fsps_pkg::CMD_W-1:0];
            win_cnt_r <= cmd_wr_en ? fsps_pkg::WINDOW_CYCLES : 3'h0;
        end
        // R12 R19: flag clears on completion, refusal or expiry
        else if (prog_end || start_load || other_cmd || spm_refused || win_expire)
        begin
            cmd_r <= '0;
            win_cnt_r <= 3'h0;
        end
        else if (spm_ok || win_cnt_r == 3'h0)
            win_cnt_r <= 3'h0;
        else
            win_cnt_r <= win_cnt_r - 3'h1;
    end

    // R4 R12: page operations hold the CPU until the array is done
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_r <= fsps_pkg::FSPS_IDLE;
            cpu_halt <= 1'b0;
            op_write_r <= 1'b0;
            wr_idx_r <= '0;
            prog_cnt_r <= '0;
        end
        else
        begin
            case (state_r)
                fsps_pkg::FSPS_IDLE:
                begin
                    wr_idx_r <= '0;
                    prog_cnt_r <= CNT_W'(PROG_CYCLES - 1);
                    op_write_r <= start_write;
                    if (start_write)
                    begin
                        state_r <= fsps_pkg::FSPS_WRITE;
                        cpu_halt <= 1'b1;
                    end
                    else if (start_erase)
                    begin
                        state_r <= fsps_pkg::FSPS_WAIT;
                        cpu_halt <= 1'b1;
                    end
                end
                fsps_pkg::FSPS_WRITE:
                begin
                    wr_idx_r <= wr_idx_r + IW'(1);
                    if (stream_end)
                        state_r <= fsps_pkg::FSPS_WAIT;
                end
                fsps_pkg::FSPS_WAIT:
                begin
                    prog_cnt_r <= prog_cnt_r - CNT_W'(1);
                    if (prog_end)
                    begin
                        state_r <= fsps_pkg::FSPS_IDLE;
                        cpu_halt <= 1'b0;
                    end
                end
                default:
                    state_r <= fsps_pkg::FSPS_IDLE;
            endcase
        end
    end

    // R7 R9: array strobes, the whole page streamed word by word
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            flash_erase <= 1'b0;
            flash_page <= 8'h00;
            flash_wr_en <= 1'b0;
            flash_wr_idx <= 6'h00;
            flash_wr_data <= 16'h0000;
        end
        else
        begin
            flash_erase <= start_erase;
            if (start_erase || start_write)
                flash_page <= z_page;
            flash_wr_en <= (state_r == fsps_pkg::FSPS_WRITE);
            flash_wr_idx <= wr_idx_r;
            flash_wr_data <= buf_rd;
        end
    end

    // Sticky status, mask and interrupt
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            status_r <= '0;
            mask_r <= '0;
            irq <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            if (wr_fire && hit_mask)
                mask_r <= pwdata[fsps_pkg::ST_W-1:0];
            irq <= |(status_r & mask_r);
        end
    end

    halt_on_start_a: assert property ( // R12
        @(posedge clk) disable iff (!rst_b)
        (start_erase || start_write) |=> cpu_halt && !idle)
        else $error("CPU not halted after page operation start");

    flag_clear_done_a: assert property ( // R12
        @(posedge clk) disable iff (!rst_b)
        prog_end |=> !cmd_r[fsps_pkg::CMD_ENABLE_BIT] && !cpu_halt && idle)
        else $error("Enable flag or halt left set after completion");

    window_expiry_a: assert property ( // R19
        @(posedge clk) disable iff (!rst_b)
        cmd_wr_en ##1 (!spm_strobe) [*4] |=> !cmd_r[fsps_pkg::CMD_ENABLE_BIT] && idle)
        else $error("Command still pending after window expired");

    window_accept_a: assert property ( // R11
        @(posedge clk) disable iff (!rst_b)
        (cmd_wr && pwdata[fsps_pkg::CMD_W-1:0] == fsps_pkg::CMD_PAGE_ERASE)
        ##1 (!spm_strobe) [*3] ##1 (spm_strobe && in_boot) |=> flash_erase && cpu_halt)
        else $error("Store-program on fourth cycle not accepted");

    boot_only_a: assert property ( // R17
        @(posedge clk) disable iff (!rst_b)
        (idle && spm_strobe && win_active && !in_boot)
        |=> !cpu_halt && !flash_erase && !cmd_r[fsps_pkg::CMD_ENABLE_BIT])
        else $error("Store-program from outside boot section executed");

    erase_page_a: assert property ( // R7
        @(posedge clk) disable iff (!rst_b)
        start_erase |=> flash_erase && flash_page == $past(z_page))
        else $error("Erase strobe or page address wrong");

    write_start_a: assert property ( // R9
        @(posedge clk) disable iff (!rst_b)
        start_write |=> !flash_wr_en ##1 (flash_wr_en && flash_wr_idx == 6'h00))
        else $error("Page write did not start at word zero");

    page_words_a: assert property ( // R4
        @(posedge clk) disable iff (!rst_b)
        $fell(flash_wr_en) |-> $past(flash_wr_idx) == 6'h3f)
        else $error("Page write stream not a whole page");

    reset_vector_a: assert property ( // R1
        @(posedge clk) disable iff (!rst_b)
        $past(rst_b) |-> reset_vec ==
            ($past(boot_reset_select_fuse) ? $past(boot_start) : fsps_pkg::APP_RESET_VEC))
        else $error("Reset vector does not follow the boot reset fuse");
endmodule // fsps_seq

// ### rtl/fsps_pkg.sv
// Shared constants and types for the flash self-program sequencer
package fsps_pkg;
    // Clock and operation timing
    localparam int CLK_PERIOD_NS = 10;
    // Erase or page write time, a plain default
    localparam int PROG_TIME_US = 4000;
    localparam int NS_PER_US = 1000;

    // Array geometry
    localparam int PAGE_WORDS = 64;
    localparam int PAGE_COUNT = 256;
    localparam int WORD_W = 16;
    localparam int IDX_W = 6;
    localparam int PAGE_W = 8;
    localparam int PC_W = 14;
    localparam int Z_W = 16;

    // Pointer fields
    localparam int Z_PAGE_HI = 14;
    localparam int Z_PAGE_LO = 7;
    localparam int Z_IDX_HI = 6;
    localparam int Z_IDX_LO = 1;

    // Command register
    localparam int CMD_W = 5;
    localparam int CMD_ENABLE_BIT = 0;
    localparam logic [4:0] CMD_PAGE_LOAD = 5'h01;
    localparam logic [4:0] CMD_PAGE_ERASE = 5'h03;
    localparam logic [4:0] CMD_PAGE_WRITE = 5'h05;
    localparam logic [2:0] WINDOW_CYCLES = 3'h4;

    // Register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_INFO = 8'h0c;
    localparam int INFO_BUSY_BIT = 16;

    // Status bits
    localparam int ST_W = 3;
    localparam int ST_DONE = 0;
    localparam int ST_TIMEOUT = 1;
    localparam int ST_REFUSED = 2;

    // Reset vectors by boot size fuses
    localparam logic [13:0] APP_RESET_VEC = 14'h0000;
    localparam logic [13:0] BOOT_START_256 = 14'h3f00;
    localparam logic [13:0] BOOT_START_512 = 14'h3e00;
    localparam logic [13:0] BOOT_START_1K = 14'h3c00;
    localparam logic [13:0] BOOT_START_2K = 14'h3800;
    localparam logic [1:0] BOOT_SIZE_FUSES_256 = 2'h3;
    localparam logic [1:0] BOOT_SIZE_FUSES_512 = 2'h2;
    localparam logic [1:0] BOOT_SIZE_FUSES_1K = 2'h1;

    typedef enum {
        FSPS_IDLE,
        FSPS_WRITE,
        FSPS_WAIT
    } fsps_state_t;
endpackage

// ### rtl/fsps_page_buf.sv
// Temporary page buffer, one flip-flop word per entry
`timescale 1ns/1ps
module fsps_page_buf #(
    parameter int WORDS = 64,
    parameter int WIDTH = 16,
    parameter int IDX_W = 6
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load_en,
    input wire logic [IDX_W-1:0] load_idx,
    input wire logic [WIDTH-1:0] load_data,
    input wire logic clear,
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_r [WORDS];

    genvar i;
    generate
        for (i = 0; i < WORDS; i++)
        begin : g_entry
            // R6: each slot loads on its own index, any order
            always_ff @(posedge clk)
            begin
                if (!rst_b || clear)
                    mem_r[i] <= '1;
                else if (load_en && load_idx == IDX_W'(i))
                    mem_r[i] <= load_data;
            end
        end
    endgenerate

    assign rd_data = mem_r[rd_idx];
endmodule // fsps_page_buf

// ### verification/fsps_cpu_model.sv
// Boot loader core model: issues store-program strobes with pointer and data pair
`timescale 1ns/1ps
module fsps_cpu_model (
    input wire logic clk,
    output logic spm_strobe,
    output logic [13:0] spm_pc,
    output logic [15:0] z_ptr,
    output logic [15:0] r1r0
);
    initial
    begin
        spm_strobe = 1'b0;
        spm_pc = 14'h0000;
        z_ptr = 16'h0000;
        r1r0 = 16'h0000;
    end

    // one instruction per command, dly edges after the write
    task automatic spm_exec(input logic [13:0] pc, input logic [15:0] z, input logic [15:0] d,
                            input int dly);
        begin
            repeat (dly - 1) @(posedge clk);
            spm_strobe <= 1'b1;
            spm_pc <= pc;
            z_ptr <= z;
            r1r0 <= d;
            @(posedge clk);
            // Released lines show the inverse so stale values never look valid
            spm_strobe <= 1'b0;
            spm_pc <= ~pc;
            z_ptr <= ~z;
            r1r0 <= ~d;
        end
    endtask
endmodule // fsps_cpu_model

// ### verification/testbench.sv
// Self-checking bench for the flash self-program sequencer
`timescale 1ns/1ps
module testbench;
    localparam int PROG = 20;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, spm_strobe, cpu_halt, flash_erase, flash_wr_en, irq, err;
    logic [13:0] spm_pc, reset_vec;
    logic [15:0] z_ptr, r1r0, flash_wr_data;
    logic fuse = 1'b0;
    logic [1:0] bsz = 2'h0;
    logic [7:0] flash_page, erase_page;
    logic [5:0] flash_wr_idx;
    logic [31:0] q;
    logic [15:0] got_buf [64];
    logic [15:0] exp_buf [64];
    logic [13:0] vec_tab [4] = '{14'h3800, 14'h3c00, 14'h3e00, 14'h3f00};
    int mismatches = 0;
    int cmp_count = 0;
    int erase_cnt = 0;
    int wr_cnt = 0;
    int halt_cnt = 0;

    always #5 clk = ~clk;

    fsps_seq #(.PROG_CYCLES(PROG)) fsps_seq_i (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .spm_strobe(spm_strobe), .spm_pc(spm_pc),
        .z_ptr(z_ptr), .r1r0(r1r0), .boot_reset_select_fuse(fuse), .boot_size_fuses(bsz),
        .reset_vec(reset_vec), .cpu_halt(cpu_halt), .flash_erase(flash_erase),
        .flash_page(flash_page), .flash_wr_en(flash_wr_en), .flash_wr_idx(flash_wr_idx),
        .flash_wr_data(flash_wr_data), .irq(irq));
    fsps_cpu_model fsps_cpu_model_i (.clk(clk), .spm_strobe(spm_strobe), .spm_pc(spm_pc),
        .z_ptr(z_ptr), .r1r0(r1r0));

    always @(posedge clk)
    begin
        if (flash_erase === 1'b1)
        begin
            erase_cnt++;
            erase_page = flash_page;
        end
        if (flash_wr_en === 1'b1)
        begin
            wr_cnt++;
            got_buf[flash_wr_idx] = flash_wr_data;
        end
        if (cpu_halt === 1'b1)
            halt_cnt++;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        begin
            cmp_count++;
            if (seen !== exp)
            begin
                mismatches++;
                $display("wrong value %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    // Waits for pready however long it takes; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            do
            begin
                @(posedge clk);
            end
            while (pready !== 1'b1);
            q = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic op(input logic [4:0] c, input logic [13:0] pc, input logic [15:0] z,
                      input logic [15:0] d, input int dly);
        int n;
        begin
            halt_cnt = 0;
            apb(1'b1, fsps_pkg::ADDR_CMD, {27'h0, c});
            fsps_cpu_model_i.spm_exec(pc, z, d, dly);
            n = 0;
            do
            begin
                apb(1'b0, fsps_pkg::ADDR_CMD, 32'h0);
                n++;
            end
            while (q[0] !== 1'b0 && n < 100);
            chk("command flag", q, 32'h0);
        end
    endtask

    task automatic end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
            if (mismatches == 0 && cmp_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    initial
    begin
        #200000;
        mismatches++;
        end_of_test();
    end

    initial
    begin
        repeat (6) @(posedge clk);
        chk("reset_vec in reset", {18'h0, reset_vec}, 32'h0);
        rst_b <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            fuse <= (i < 4);
            bsz <= 2'(i);
            repeat (2) @(posedge clk);
            apb(1'b0, fsps_pkg::ADDR_INFO, 32'h0);
            chk("info vector", q, (i < 4) ? {18'h0, vec_tab[i]} : 32'h0);
        end
        fuse <= 1'b1;
        bsz <= 2'h3;
        $display("test reset vector done");
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", q, 32'h0);
        apb(1'b1, fsps_pkg::ADDR_MASK, 32'hffffffff);
        apb(1'b0, fsps_pkg::ADDR_MASK, 32'h0);
        chk("mask", q, 32'h7);
        apb(1'b1, fsps_pkg::ADDR_MASK, 32'h0);
        apb(1'b0, fsps_pkg::ADDR_STATUS, 32'h0);
        chk("status after reset", q, 32'h0);
        $display("test registers done");
        for (int k = 0; k < 64; k++)
            exp_buf[k] = 16'hffff;
        for (int p = 0; p < 2; p++)
        begin
            for (int k = 0; k < 3 && p == 0; k++)
            begin
                exp_buf[6'h3f - 6'(k * 29)] = 16'h5a00 + 16'(k);
                op(fsps_pkg::CMD_PAGE_LOAD, 14'h3f10, {1'b0, 8'hff, 6'h3f - 6'(k * 29), 1'b0},
                   16'h5a00 + 16'(k), 4 - k);
                apb(1'b0, fsps_pkg::ADDR_STATUS, 32'h0);
                chk("load status", q, 32'h1);
                chk("no word write", wr_cnt, 0);
            end
            op(fsps_pkg::CMD_PAGE_ERASE, 14'h3f20, {1'b0, 8'hff, 7'h5b}, 16'hbeef,
               4 - 3 * p);
            chk("erase count", erase_cnt, p + 1);
            chk("erase page", {24'h0, erase_page}, 32'hff);
            chk("erase halt", halt_cnt, PROG);
            wr_cnt = 0;
            op(fsps_pkg::CMD_PAGE_WRITE, 14'h3f30, {1'b0, 8'hff, 7'h00}, 16'h0bad, 3);
            chk("page words", wr_cnt, 64);
            chk("write page", {24'h0, flash_page}, 32'hff);
            for (int k = 0; k < 64; k++)
            begin
                chk("buffer word", {16'h0, got_buf[k]}, {16'h0, exp_buf[k]});
                exp_buf[k] = 16'hffff;
            end
            apb(1'b0, fsps_pkg::ADDR_STATUS, 32'h0);
        end
        $display("test page update done");
        op(fsps_pkg::CMD_PAGE_ERASE, 14'h3f20, 16'h7f80, 16'h0, 5);
        apb(1'b0, fsps_pkg::ADDR_STATUS, 32'h0);
        chk("late status", q, 32'h2);
        op(fsps_pkg::CMD_PAGE_ERASE, 14'h3eff, 16'h7f80, 16'h0, 1);
        apb(1'b0, fsps_pkg::ADDR_STATUS, 32'h0);
        chk("outside boot status", q, 32'h4);
        chk("no erase", erase_cnt, 2);
        op(5'h11, 14'h3f10, 16'h0000, 16'h0000, 2);
        apb(1'b0, fsps_pkg::ADDR_STATUS, 32'h0);
        chk("other code status", q, 32'h1);
        chk("other code no erase", erase_cnt, 2);
        chk("other code no halt", halt_cnt, 0);
        $display("test refusals done");
        apb(1'b1, fsps_pkg::ADDR_MASK, 32'h1);
        op(fsps_pkg::CMD_PAGE_LOAD, 14'h3f10, 16'h7f82, 16'h1111, 1);
        repeat (2) @(posedge clk);
        chk("irq raised", {31'h0, irq}, 32'h1);
        apb(1'b1, fsps_pkg::ADDR_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, fsps_pkg::ADDR_MASK, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        apb(1'b0, fsps_pkg::ADDR_STATUS, 32'h0);
        chk("irq status", q, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        $display("test interrupt done");
        end_of_test();
    end
endmodule // testbench
